// [core/mpa_pkg.sv]
package mpa_pkg;

    // ==========================================================
    // Page range and counter geometry
    // ==========================================================
    localparam int unsigned MPA_CNT_W = 10;
    localparam logic [9:0] MPA_MIN_PAGE = 10'h001;
    localparam logic [9:0] MPA_MAX_PAGE = 10'h3FF;
    localparam logic [9:0] MPA_ZERO_PAGE = 10'h000;
    localparam logic [9:0] MPA_RESERVED_DEFAULT = 10'h000;

    // ==========================================================
    // Counter control codes
    // ==========================================================
    localparam logic [1:0] MPA_CC_RESET = 2'h1;
    localparam logic [1:0] MPA_CC_INCR = 2'h2;

    // ==========================================================
    // Page allocation field layout within a management octet
    // ==========================================================
    localparam int unsigned MPA_FLD_RES_BIT = 4;
    localparam int unsigned MPA_FLD_CHK_LSB = 2;
    localparam int unsigned MPA_FLD_CTL_LSB = 0;

    // ==========================================================
    // APB register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] MPA_REG_CTRL = 8'h00;
    localparam logic [7:0] MPA_REG_RESV = 8'h04;
    localparam logic [7:0] MPA_REG_HEAD = 8'h08;
    localparam logic [7:0] MPA_REG_CNTA = 8'h0C;
    localparam logic [7:0] MPA_REG_CNTB = 8'h10;
    localparam logic [7:0] MPA_REG_STAT = 8'h14;
    localparam int unsigned MPA_CTRL_HEAD_A_BIT = 0;
    localparam int unsigned MPA_CTRL_HEAD_B_BIT = 1;
    localparam int unsigned MPA_CTRL_ENABLE_BIT = 2;

    typedef enum logic [1:0] {
        MPA_BUS_IDLE,
        MPA_BUS_BELOW,
        MPA_BUS_EQUAL
    } mpa_bus_e;

    typedef enum logic {
        MPA_HEAD_DISABLED,
        MPA_HEAD_ENABLED
    } mpa_head_e;

    // One page allocation field as carried on a bus.
    typedef struct packed {
        logic reserved;
        logic [1:0] check;
        logic [1:0] control;
    } mpa_field_s;

    // Empty management octet arriving on one bus, with its field.
    typedef struct packed {
        logic valid;
        mpa_field_s field;
    } mpa_slot_s;

    // Page offer given to the keep-page or get-page machine.
    typedef struct packed {
        logic valid;
        logic reserved;
        logic [9:0] page;
    } mpa_offer_s;

endpackage

// [core/mpa_page_alloc.sv]
// Behaviour
// - One identifier value per allocated page.
// - Field holds reservation, check, control subfields.
// - Control code sets next associated page.
// - Reservation bit marks page reserved or free.
// - Check subfield verifies counter against head.
// - Only active head A originates fields.
// - Centrally reserved pages never offered to nodes; here offered, reserved bit set.
// - Bus A fields update and verify counter A.
// - Keep-page machine offered bus A page.
// - Head B echoes bus A field unchanged.
// - Bus B fields update and verify counter B.
// - Get-page machine offered bus B page.
// - Head A discards fields ending bus B.
// - Head A normally issues increment code.
// - Reset code after full increment run.
// - Head counter chooses control code per octet.
// - Head counter machine disabled at power-up.
// - Enabled when stable, disabled when waiting.
// - Increment below top, reload one at top.
// - Codes 01 reset, 10 increment, else error.
// - Check subfield is counter modulo four.
// - Reserved when counter at most reserved count.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module mpa_page_alloc
    import mpa_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mpa_slot_s bus_a_in,
    input wire mpa_slot_s bus_b_in,
    input wire logic head_stable,
    input wire logic head_waiting,
    output mpa_slot_s bus_a_out,
    output mpa_slot_s bus_b_out,
    output mpa_offer_s keep_offer,
    output mpa_offer_s get_offer,
    output logic check_err_a,
    output logic check_err_b
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic head_a;
        logic head_b;
        logic sw_enable;
        logic [9:0] reserved_page_count;
        mpa_head_e page_count_fsm;
        logic [9:0] head_page_counter;
        mpa_bus_e fsm_a;
        mpa_bus_e fsm_b;
        logic [9:0] bus_a_page_counter;
        logic [9:0] bus_b_page_counter;
        mpa_slot_s out_a;
        mpa_slot_s out_b;
        mpa_offer_s keep;
        mpa_offer_s get;
        logic err_a;
        logic err_b;
        logic err_a_sticky;
        logic err_b_sticky;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } mpa_state_s;

    mpa_state_s state_reg;
    mpa_state_s state_next;

    // Next counter value for a per-bus machine, with error detection.
    function automatic logic [10:0] bus_step(input logic [9:0] cnt, input mpa_bus_e st,
                                             input mpa_field_s f);
        logic [9:0] nxt;
        logic bad;
        nxt = MPA_ZERO_PAGE;
        bad = 1'b0;
        unique case (f.control)
            MPA_CC_RESET: begin
                nxt = MPA_MIN_PAGE;
                // A reset is legal only from the top page or while idle.
                bad = (st == MPA_BUS_BELOW);
            end
            MPA_CC_INCR: begin
                if (st == MPA_BUS_BELOW && cnt != MPA_MAX_PAGE) begin
                    nxt = cnt + 10'h001;
                end else if (st == MPA_BUS_IDLE) begin
                    nxt = MPA_ZERO_PAGE;
                end else begin
                    bad = 1'b1;
                end
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        // Check subfield tests the page held before this update.
        if (st != MPA_BUS_IDLE && f.check != cnt[1:0]) begin
            bad = 1'b1;
        end
        if (bad) begin
            nxt = MPA_ZERO_PAGE;
        end
        return {bad, nxt};
    endfunction

    function automatic mpa_bus_e bus_state(input logic [10:0] r);
        if (r[10] || r[9:0] == MPA_ZERO_PAGE) begin
            return MPA_BUS_IDLE;
        end else if (r[9:0] == MPA_MAX_PAGE) begin
            return MPA_BUS_EQUAL;
        end else begin
            return MPA_BUS_BELOW;
        end
    endfunction

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic [10:0] ra;
        logic [10:0] rb;
        logic en;
        logic apb_hit;
        state_next = state_reg;
        ra = 11'h000;
        rb = 11'h000;
        en = 1'b0;
        apb_hit = psel && penable && !state_reg.ready;

        // Single-cycle pulses fall back every cycle.
        state_next.out_a.valid = 1'b0;
        state_next.out_b.valid = 1'b0;
        state_next.keep.valid = 1'b0;
        state_next.get.valid = 1'b0;
        state_next.err_a = 1'b0;
        state_next.err_b = 1'b0;
        state_next.ready = 1'b0;
        state_next.slverr = 1'b0;

        // Enabled while head status stable and software allows it.
        en = state_reg.head_a && state_reg.sw_enable && head_stable && !head_waiting;

        // Head of bus A generates the field for each empty octet on A.
        if (state_reg.head_a && bus_a_in.valid) begin
            state_next.out_a.valid = 1'b1;
            // All three subfields from the sample before the update.
            state_next.out_a.field.check = state_reg.head_page_counter[1:0];
            state_next.out_a.field.reserved =
                (state_reg.head_page_counter <= state_reg.reserved_page_count);
            unique case (state_reg.page_count_fsm)
                MPA_HEAD_ENABLED: begin
                    if (!en) begin
                        state_next.out_a.field.control = MPA_CC_RESET;
                        state_next.head_page_counter = MPA_ZERO_PAGE;
                        state_next.page_count_fsm = MPA_HEAD_DISABLED;
                    end else if (state_reg.head_page_counter == MPA_MAX_PAGE) begin
                        state_next.out_a.field.control = MPA_CC_RESET;
                        state_next.head_page_counter = MPA_MIN_PAGE;
                    end else begin
                        state_next.out_a.field.control = MPA_CC_INCR;
                        state_next.head_page_counter = state_reg.head_page_counter + 10'h001;
                    end
                end
                MPA_HEAD_DISABLED: begin
                    if (en) begin
                        state_next.out_a.field.control = MPA_CC_RESET;
                        state_next.head_page_counter = MPA_MIN_PAGE;
                        state_next.page_count_fsm = MPA_HEAD_ENABLED;
                    end else begin
                        state_next.out_a.field.control = MPA_CC_INCR;
                    end
                end
            endcase
        end else if (!state_reg.head_a) begin
            // Losing the head role drops the machine to disabled.
            state_next.page_count_fsm = MPA_HEAD_DISABLED;
            state_next.head_page_counter = MPA_ZERO_PAGE;
            // Non-head nodes relay the field on bus A as it came.
            state_next.out_a = bus_a_in;
        end

        // Every node tracks bus A with its own counter.
        if (bus_a_in.valid) begin
            ra = bus_step(state_reg.bus_a_page_counter, state_reg.fsm_a, bus_a_in.field);
            // Offer the page before the counter moves.
            state_next.keep.valid = state_reg.bus_a_page_counter != MPA_ZERO_PAGE;
            state_next.keep.reserved = bus_a_in.field.reserved;
            state_next.keep.page = state_reg.bus_a_page_counter;
            state_next.bus_a_page_counter = ra[9:0];
            state_next.fsm_a = bus_state(ra);
            state_next.err_a = ra[10] && state_reg.fsm_a != MPA_BUS_IDLE;
        end

        // Every node tracks bus B with its own counter.
        if (bus_b_in.valid) begin
            rb = bus_step(state_reg.bus_b_page_counter, state_reg.fsm_b, bus_b_in.field);
            state_next.get.valid = state_reg.bus_b_page_counter != MPA_ZERO_PAGE;
            state_next.get.reserved = bus_b_in.field.reserved;
            state_next.get.page = state_reg.bus_b_page_counter;
            state_next.bus_b_page_counter = rb[9:0];
            state_next.fsm_b = bus_state(rb);
            state_next.err_b = rb[10] && state_reg.fsm_b != MPA_BUS_IDLE;
        end

        // Head B echoes the bus A end field; head A drops bus B's end.
        if (state_reg.head_b) begin
            if (bus_a_in.valid) begin
                state_next.out_b = bus_a_in;
            end
        end else if (!state_reg.head_a) begin
            state_next.out_b = bus_b_in;
        end else begin
            state_next.out_b.valid = 1'b0;
        end

        // Sticky errors: a new error wins over a software clear.
        if (apb_hit && pwrite && paddr == MPA_REG_STAT) begin
            state_next.err_a_sticky = state_reg.err_a_sticky && !pwdata[0];
            state_next.err_b_sticky = state_reg.err_b_sticky && !pwdata[1];
        end
        if (state_next.err_a) begin
            state_next.err_a_sticky = 1'b1;
        end
        if (state_next.err_b) begin
            state_next.err_b_sticky = 1'b1;
        end

        // APB slave, one wait state; unmapped addresses answer with an error.
        if (apb_hit) begin
            state_next.ready = 1'b1;
            state_next.rdata = 32'h00000000;
            unique case (paddr)
                MPA_REG_CTRL: begin
                    if (pwrite) begin
                        state_next.head_a = pwdata[MPA_CTRL_HEAD_A_BIT];
                        state_next.head_b = pwdata[MPA_CTRL_HEAD_B_BIT];
                        state_next.sw_enable = pwdata[MPA_CTRL_ENABLE_BIT];
                    end
                    state_next.rdata[2:0] = {state_reg.sw_enable, state_reg.head_b, state_reg.head_a};
                end
                MPA_REG_RESV: begin
                    if (pwrite) begin
                        state_next.reserved_page_count = pwdata[9:0];
                    end
                    state_next.rdata[9:0] = state_reg.reserved_page_count;
                end
                MPA_REG_HEAD: begin
                    state_next.rdata[9:0] = state_reg.head_page_counter;
                    state_next.rdata[16] = (state_reg.page_count_fsm == MPA_HEAD_ENABLED);
                end
                MPA_REG_CNTA: begin
                    state_next.rdata[9:0] = state_reg.bus_a_page_counter;
                    state_next.rdata[17:16] = state_reg.fsm_a;
                end
                MPA_REG_CNTB: begin
                    state_next.rdata[9:0] = state_reg.bus_b_page_counter;
                    state_next.rdata[17:16] = state_reg.fsm_b;
                end
                MPA_REG_STAT: begin
                    state_next.rdata[1:0] = {state_reg.err_b_sticky, state_reg.err_a_sticky};
                end
                default: begin
                    state_next.slverr = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // State register; everything clears to a disabled, idle node.
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.page_count_fsm <= MPA_HEAD_DISABLED;
            state_reg.fsm_a <= MPA_BUS_IDLE;
            state_reg.fsm_b <= MPA_BUS_IDLE;
            state_reg.reserved_page_count <= MPA_RESERVED_DEFAULT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;
    assign bus_a_out = state_reg.out_a;
    assign bus_b_out = state_reg.out_b;
    assign keep_offer = state_reg.keep;
    assign get_offer = state_reg.get;
    assign check_err_a = state_reg.err_a;
    assign check_err_b = state_reg.err_b;

endmodule

`default_nettype wire

// [bench/mpa_page_alloc_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checker for the page allocator
// ==========================================================
module mpa_page_alloc_props
    import mpa_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire mpa_slot_s bus_a_in,
    input wire mpa_slot_s bus_b_in,
    input wire logic head_stable,
    input wire logic head_waiting,
    input wire mpa_slot_s bus_a_out,
    input wire mpa_slot_s bus_b_out,
    input wire mpa_offer_s keep_offer,
    input wire mpa_offer_s get_offer
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] ctl_reg;
    logic en_d;
    logic prv_en;
    mpa_field_s prv;

    // The head counter is private, so its steps are judged from consecutive fields.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= 3'h0;
            en_d <= 1'h0;
            prv_en <= 1'h0;
            prv <= '0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == MPA_REG_CTRL) begin
                ctl_reg <= pwdata[2:0];
            end
            en_d <= ctl_reg[0] && ctl_reg[2] && head_stable && !head_waiting;
            if (bus_a_out.valid) begin
                prv_en <= en_d;
                prv <= bus_a_out.field;
            end
        end
    end

    property p_rdy_wait; psel && penable && !pready |=> pready ##1 !pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("Access not answered after one wait state.");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("Slave error outside an answer.");
    property p_a_fwd; bus_a_in.valid && !ctl_reg[0] |=> bus_a_out == $past(bus_a_in); endproperty
    a_a_fwd: assert property (p_a_fwd) else $error("Bus A field altered by a plain node.");
    property p_b_echo; bus_a_in.valid && ctl_reg[1] |=> bus_b_out == $past(bus_a_in); endproperty
    a_b_echo: assert property (p_b_echo) else $error("Bus B head did not echo bus A.");
    property p_b_drop; bus_b_in.valid && ctl_reg[1:0] == 2'h1 |=> !bus_b_out.valid; endproperty
    a_b_drop: assert property (p_b_drop) else $error("Head A forwarded a bus B field.");
    property p_b_fwd; bus_b_in.valid && ctl_reg[1:0] == 2'h0 |=> bus_b_out == $past(bus_b_in); endproperty
    a_b_fwd: assert property (p_b_fwd) else $error("Bus B field altered in transit.");
    property p_incr; bus_a_out.valid && ctl_reg[0] && en_d && prv_en && prv.control == MPA_CC_INCR
        |-> bus_a_out.field.check == prv.check + 2'h1; endproperty
    a_incr: assert property (p_incr) else $error("Check subfield did not advance.");
    property p_reload; bus_a_out.valid && ctl_reg[0] && en_d && prv_en && prv.control == MPA_CC_RESET
        |-> bus_a_out.field.check == 2'h1 && bus_a_out.field.control == MPA_CC_INCR; endproperty
    a_reload: assert property (p_reload) else $error("Counter did not restart at one.");
    property p_idle; bus_a_out.valid && ctl_reg[0] && !en_d && !prv_en
        |-> bus_a_out.field == {1'h1, 2'h0, MPA_CC_INCR}; endproperty
    a_idle: assert property (p_idle) else $error("Disabled head sent a wrong field.");
    property p_stop; bus_a_out.valid && ctl_reg[0] && !en_d && prv_en
        |-> bus_a_out.field.control == MPA_CC_RESET; endproperty
    a_stop: assert property (p_stop) else $error("Disable did not send the reset code.");
    property p_keep; keep_offer.valid |-> keep_offer.page != MPA_ZERO_PAGE; endproperty
    a_keep: assert property (p_keep) else $error("Keep offer of page zero.");
    property p_get; get_offer.valid |-> get_offer.page != MPA_ZERO_PAGE; endproperty
    a_get: assert property (p_get) else $error("Get offer of page zero.");
endmodule

bind mpa_page_alloc mpa_page_alloc_props i_mpa_page_alloc_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .bus_a_in, .bus_b_in, .head_stable, .head_waiting, .bus_a_out,
    .bus_b_out, .keep_offer, .get_offer);
`default_nettype wire

// [bench/mpa_far_node.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Peer nodes feeding empty management octets
// ==========================================================
module mpa_far_node
    import mpa_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic send_a,
    input wire logic send_b,
    input wire mpa_field_s fld_a,
    input wire mpa_field_s fld_b,
    output wire mpa_slot_s slot_a,
    output wire mpa_slot_s slot_b
);
    mpa_field_s last_a;
    mpa_field_s last_b;

    // Between octets the field lines toggle, so a stale value can never pass for a fresh one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_a <= '0;
            last_b <= '0;
        end else begin
            last_a <= slot_a.field;
            last_b <= slot_b.field;
        end
    end

    // Whole three-part fields with any control code, 00 and 11 included.
    assign slot_a = send_a ? {1'h1, fld_a} : {1'h0, ~last_a};
    assign slot_b = send_b ? {1'h1, fld_b} : {1'h0, ~last_b};
endmodule
`default_nettype wire

// [bench/mpa_page_alloc_test.sv]
`timescale 1ns/100ps
`default_nettype none
module mpa_page_alloc_test
    import mpa_pkg::*;
();
    logic pclk, presetn, psel, penable, pwrite, send_a, send_b, head_stable, head_waiting;
    logic pready, pslverr, check_err_a, check_err_b, hst;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] hc, resv;
    mpa_field_s fld_a, fld_b;
    mpa_slot_s bus_a_in, bus_b_in, bus_a_out, bus_b_out;
    mpa_offer_s keep_offer, get_offer;
    mpa_field_s qa[$];
    logic [32:0] qr[$];
    // Offer notes are {bus, reserved, page}; error notes are {10'h0, error B, error A}.
    logic [11:0] qo[$];
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    mpa_page_alloc i_mpa_page_alloc (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .bus_a_in, .bus_b_in, .head_stable, .head_waiting, .bus_a_out, .bus_b_out,
        .keep_offer, .get_offer, .check_err_a, .check_err_b);
    mpa_far_node i_mpa_far_node (.pclk, .presetn, .send_a, .send_b, .fld_a, .fld_b, .slot_a(bus_a_in),
        .slot_b(bus_b_in));

    // Clock at 10 MHz.
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // Result watcher: oldest note against each answer
    // ==========================================================
    always @(posedge pclk) begin
        cyc++;
        if (bus_a_out.valid) chk("bus_a_out", qa.pop_front(), bus_a_out.field);
        if (pready && !pwrite) chk("prdata", qr.pop_front(), {pslverr, prdata});
        if (keep_offer.valid) chk("keep_offer", {21'h0, qo.pop_front()}, {22'h0, keep_offer[10:0]});
        if (get_offer.valid) chk("get_offer", {21'h0, qo.pop_front()}, {21'h0, 1'h1, get_offer[10:0]});
        if (check_err_a || check_err_b) begin
            chk("check_err", {21'h0, qo.pop_front()}, {31'h0, check_err_b, check_err_a});
        end
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // One APB transfer; the request holds until pready is seen.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e = '0);
        if (!w) qr.push_back(e);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic oct(input logic b, input mpa_field_s f);
        send_a <= !b;
        send_b <= b;
        fld_a <= f;
        fld_b <= f;
        @(posedge pclk);
        send_a <= 1'h0;
        send_b <= 1'h0;
        @(posedge pclk);
    endtask

    // Head of bus A: model of the head counter gives each expected field.
    task automatic head_run(input int n, input logic en);
        mpa_field_s e;
        repeat (n) begin
            e = {hc <= resv, hc[1:0], MPA_CC_INCR};
            if (en && (!hst || hc == MPA_MAX_PAGE)) begin
                e.control = MPA_CC_RESET;
                hc = MPA_MIN_PAGE;
            end else if (en) hc++;
            else if (hst) begin
                e.control = MPA_CC_RESET;
                hc = MPA_ZERO_PAGE;
            end
            hst = en;
            qa.push_back(e);
            // Increment codes keep every node counter idle, so no offers or errors appear here.
            oct(1'h0, mpa_field_s'({3'($urandom), MPA_CC_INCR}));
        end
    endtask

    // Plain node counter: a reset, two good increments, then one bad field.
    task automatic cnt_seq(input logic b, input logic [1:0] bad);
        logic [7:0] ca;
        mpa_field_s f[4];
        ca = b ? MPA_REG_CNTB : MPA_REG_CNTA;
        f = '{{1'h0, 2'h0, MPA_CC_RESET}, {1'h1, 2'h1, MPA_CC_INCR}, {1'h0, 2'h2, MPA_CC_INCR}, {1'h0, 2'h0, bad}};
        for (int i = 0; i < 4; i++) begin
            if (!b) qa.push_back(f[i]);
            if (i > 0) qo.push_back({b, f[i].reserved, 10'(i)});
            if (i == 3) qo.push_back({10'h0, b, !b});
            oct(b, f[i]);
            if (i == 2) apb(1'h0, ca, 32'h0, 33'h1_0003);
        end
        apb(1'h0, MPA_REG_STAT, 32'h0, {31'h0, b, !b});
        apb(1'h1, MPA_REG_STAT, 32'h3);
        apb(1'h0, MPA_REG_STAT, 32'h0, 33'h0);
        apb(1'h0, ca, 32'h0, 33'h0);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, send_a, send_b, head_stable, head_waiting, hst} = '0;
        {paddr, pwdata, fld_a, fld_b, hc} = '0;
        void'($urandom(2718));
        resv = 10'($urandom % 8 + 1);
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) apb(1'h0, 8'(4 * i), 32'h0, 33'h0);
        apb(1'h0, 8'h18, 32'h0, {1'h1, 32'h0});
        $display("Test reset values done");
        apb(1'h1, MPA_REG_CTRL, 32'h1);
        apb(1'h1, MPA_REG_RESV, {22'h0, resv});
        head_stable <= 1'h1;
        head_run(3, 1'h0);
        oct(1'h1, mpa_field_s'({3'($urandom), MPA_CC_INCR}));
        apb(1'h1, MPA_REG_CTRL, 32'h5);
        head_run(1030, 1'h1);
        head_waiting <= 1'h1;
        head_run(2, 1'h0);
        head_waiting <= 1'h0;
        head_run(2, 1'h1);
        apb(1'h1, MPA_REG_HEAD, 32'hFFFF_FFFF);
        apb(1'h0, MPA_REG_HEAD, 32'h0, {17'h1, 6'h0, hc});
        $display("Test head of bus done");
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, MPA_REG_CTRL, (i == 3) ? 32'h0 : 32'h2);
            cnt_seq(i == 3, 2'(i));
        end
        $display("Test node counters done");
        summarize();
    end
endmodule
`default_nettype wire
